// >>> include/ptb_pkg.sv
/*
 * ptb_pkg: shared constants for the transmit buffer pool and credit tracker.
 * Assumes a single clock domain and APB register access with 32-bit data.
 */
package ptb_pkg;
    // tlp class codes on the load, send and receive ports
    localparam logic [1:0] CLS_POSTED = 2'h0;
    localparam logic [1:0] CLS_NONPOSTED = 2'h1;
    localparam logic [1:0] CLS_COMPLETION = 2'h2;
    localparam logic [1:0] CLS_ATOMIC = 2'h3;
    // credit pool indices
    localparam int POOL_P = 0;
    localparam int POOL_NP = 1;
    localparam int POOL_CPL = 2;
    // credit view select codes
    localparam logic [2:0] VIEW_RX_AVAIL = 3'h0;
    localparam logic [2:0] VIEW_RX_LIMIT = 3'h1;
    localparam logic [2:0] VIEW_RX_USED = 3'h2;
    localparam logic [2:0] VIEW_TX_AVAIL = 3'h4;
    localparam logic [2:0] VIEW_TX_LIMIT = 3'h5;
    localparam logic [2:0] VIEW_TX_USED = 3'h6;
    localparam logic [7:0] HDR_INFINITE = 8'h7f;
    localparam logic [11:0] DATA_INFINITE = 12'h7ff;
    localparam int DW_PER_DATA_CREDIT = 4;
    localparam int HDR_DW_MAX = 4;
    localparam int DIGEST_DW = 1;
    // register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DEVCTL = 8'h08;
    localparam logic [7:0] REG_CONFIG = 8'h0c;
    localparam int CTRL_TX_ENABLE = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam int STATUS_INFLIGHT_LSB = 8;
    localparam int STATUS_NP_BLOCKED = 16;
    localparam int CONFIG_PERF_BIT = 16;
    localparam int CONFIG_EP_BIT = 17;

    function automatic int pool_size(input int payload, input bit high);
        case (payload)
            128: return high ? 32 : 26;
            256: return high ? 29 : 14;
            512: return high ? 30 : 15;
            default: return high ? 31 : 15;
        endcase
    endfunction

    function automatic int pd_init(input int payload, input bit high);
        case (payload)
            128, 256: return high ? 154 : 77;
            512: return high ? 308 : 154;
            default: return high ? 616 : 308;
        endcase
    endfunction

    function automatic int ph_init(input bit high);
        return high ? 32 : 22;
    endfunction

    function automatic int cplh_init(input bit high);
        return high ? 36 : 26;
    endfunction

    localparam int NPH_INIT = 12;
    localparam int NPD_INIT = 12;
endpackage

// >>> core/ptb_entry_mem.sv
/*
 * ptb_entry_mem: small descriptor store, one write port and one read port.
 * Read data come from a register one edge after the address; the caller
 * allows for that latency.
 */
`timescale 1ns/1ps
module ptb_entry_mem #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    initial begin
        if (DEPTH < 2 || WIDTH < 1) begin
            $error("ptb_entry_mem: bad size");
        end
    end

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// >>> core/ptb_core.sv
/*
 * ptb_core: transmit buffer pool with ordered send and non-posted bypass,
 * plus receive and transmit flow-control credit tracking and views.
 * Assumes one clock; all inputs come from logic on that clock; the link
 * layer pulses link_ack once per acknowledged tlp, oldest first.
 */
`timescale 1ns/1ps
module ptb_core #(
    parameter int PAYLOAD_BYTES = 256,
    parameter bit HIGH_PERF = 1'b1,
    parameter bit ENDPOINT = 1'b1,
    parameter bit X8_GEN2_128 = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic user_load_valid,
    input wire logic [1:0] user_load_class,
    input wire logic [8:0] user_load_len,
    output logic user_load_ready,
    input wire logic config_management_unit_valid,
    input wire logic [1:0] config_management_unit_class,
    input wire logic [8:0] config_management_unit_len,
    output logic config_management_unit_ready,
    output logic [5:0] transmit_buffers_free,
    input wire logic np_credit_blocked,
    input wire logic link_ack,
    output logic tx_send_valid,
    output logic [1:0] tx_send_class,
    output logic [8:0] tx_send_len,
    input wire logic rx_write_valid,
    input wire logic [1:0] rx_write_class,
    input wire logic [8:0] rx_write_len,
    input wire logic rx_read_valid,
    input wire logic [1:0] rx_read_class,
    input wire logic [8:0] rx_read_len,
    input wire logic fc_update_valid,
    input wire logic [1:0] fc_update_class,
    input wire logic [7:0] fc_update_hdr,
    input wire logic [11:0] fc_update_data,
    input wire logic [2:0] credit_view_select,
    output logic [7:0] posted_header_credits,
    output logic [11:0] posted_data_credits,
    output logic [7:0] nonposted_header_credits,
    output logic [11:0] nonposted_data_credits,
    output logic [7:0] completion_header_credits,
    output logic [11:0] completion_data_credits,
    input wire logic [15:0] device_control_in,
    output logic [15:0] device_control
);
    localparam int POOL = ptb_pkg::pool_size(PAYLOAD_BYTES, HIGH_PERF);
    localparam int BUF_DW = ptb_pkg::HDR_DW_MAX + PAYLOAD_BYTES / 4 + ptb_pkg::DIGEST_DW;
    localparam logic [5:0] POOL6 = 6'(POOL);
    localparam int EW = 17;

    initial begin
        if (!(PAYLOAD_BYTES inside {128, 256, 512, 1024})) begin
            $error("ptb_core: payload capability not supported");
        end
        if (PAYLOAD_BYTES == 1024 && X8_GEN2_128) begin
            $error("ptb_core: 1024 bytes not offered on this datapath");
        end
        if (BUF_DW >= 512) begin
            $error("ptb_core: buffer words exceed the length field");
        end
    end

    typedef enum logic [0:0] {ST_WAIT = 1'b0, ST_PICK = 1'b1} ptb_sched_e;

    function automatic logic [1:0] pool_of(input logic [1:0] cls);
        if (cls == ptb_pkg::CLS_POSTED) return 2'h0;
        if (cls == ptb_pkg::CLS_COMPLETION) return 2'h2;
        return 2'h1;
    endfunction

    function automatic logic [11:0] data_credits(input logic [8:0] len_dw);
        return 12'((len_dw + 9'(ptb_pkg::DW_PER_DATA_CREDIT - 1)) >> 2);
    endfunction

    // ---------------- load, buffer pool, send ----------------
    logic [5:0] free_q, free_d, inflight_q, inflight_d;
    logic [5:0] seq_q, seq_d;
    logic [4:0] wp_q [2], wp_d [2], rp_q [2], rp_d [2];
    logic [5:0] cnt_q [2], cnt_d [2], vis_q [2];
    logic [EW-1:0] head [2];
    logic wr_en [2];
    logic [EW-1:0] wr_entry;
    ptb_sched_e st_q, st_d;
    logic send_d, uready_d, cready_d;
    logic [1:0] send_cls_d;
    logic [8:0] send_len_d;
    logic [31:0] ctrl_q, ctrl_d;
    logic acc_user, acc_cfg, take, release_buf, pick_np, pick_pc;
    logic [1:0] ld_cls;
    logic [8:0] ld_len;
    logic np_older;

    assign acc_cfg = config_management_unit_valid && config_management_unit_ready;
    assign acc_user = user_load_valid && user_load_ready && !acc_cfg;
    assign take = acc_cfg || acc_user;
    assign ld_cls = acc_cfg ? config_management_unit_class : user_load_class;
    assign ld_len = acc_cfg ? config_management_unit_len : user_load_len;
    assign wr_entry = {ld_cls, seq_q, ld_len};
    assign release_buf = link_ack && inflight_q != 6'h0;
    assign np_older = 6'(head[0][14:9] - head[1][14:9]) >= 6'h20;

    for (genvar g = 0; g < 2; g++) begin : g_queue
        assign wr_en[g] = take && ((pool_of(ld_cls) == 2'h1) == (g == 0));
        ptb_entry_mem #(.WIDTH(EW), .DEPTH(32)) u_mem (
            .clk(clk),
            .wr_en(wr_en[g]),
            .wr_addr(wp_q[g]),
            .wr_data(wr_entry),
            .rd_addr(rp_q[g]),
            .rd_data(head[g])
        );
    end

    always_comb begin
        pick_np = 1'b0;
        pick_pc = 1'b0;
        if (st_q == ST_PICK && ctrl_q[ptb_pkg::CTRL_TX_ENABLE]) begin
            if (vis_q[0] != 6'h0 && !np_credit_blocked &&
                    (vis_q[1] == 6'h0 || np_older)) begin
                pick_np = 1'b1;
            end else if (vis_q[1] != 6'h0) begin
                pick_pc = 1'b1;
            end
        end
        st_d = (pick_np || pick_pc) ? ST_WAIT : ST_PICK;
        send_d = pick_np || pick_pc;
        send_cls_d = pick_np ? head[0][16:15] : head[1][16:15];
        send_len_d = pick_np ? head[0][8:0] : head[1][8:0];
        for (int q = 0; q < 2; q++) begin
            wp_d[q] = wr_en[q] ? wp_q[q] + 5'h1 : wp_q[q];
            rp_d[q] = ((q == 0) ? pick_np : pick_pc) ? rp_q[q] + 5'h1 : rp_q[q];
            cnt_d[q] = cnt_q[q] + {5'h0, wr_en[q]} - {5'h0, rp_d[q] != rp_q[q]};
        end
        seq_d = take ? seq_q + 6'h1 : seq_q;
        // one whole buffer per tlp, whatever its length
        free_d = free_q - {5'h0, take} + {5'h0, release_buf};
        inflight_d = inflight_q + {5'h0, send_d} - {5'h0, release_buf};
        cready_d = free_d != 6'h0;
        uready_d = free_d != 6'h0 && !(config_management_unit_valid && cready_d);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= ST_PICK;
            free_q <= POOL6;
            inflight_q <= 6'h0;
            seq_q <= 6'h0;
            wp_q <= '{5'h0, 5'h0};
            rp_q <= '{5'h0, 5'h0};
            cnt_q <= '{6'h0, 6'h0};
            vis_q <= '{6'h0, 6'h0};
            tx_send_valid <= 1'b0;
            tx_send_class <= 2'h0;
            tx_send_len <= 9'h0;
            user_load_ready <= 1'b0;
            config_management_unit_ready <= 1'b0;
            transmit_buffers_free <= 6'h0;
        end else begin
            st_q <= st_d;
            free_q <= free_d;
            inflight_q <= inflight_d;
            seq_q <= seq_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            vis_q <= cnt_q;
            tx_send_valid <= send_d;
            tx_send_class <= send_cls_d;
            tx_send_len <= send_len_d;
            user_load_ready <= uready_d;
            config_management_unit_ready <= cready_d;
            transmit_buffers_free <= free_d;
        end
    end

    // ---------------- credit accounting ----------------
    logic [7:0] rxh_in_q [3], rxh_out_q [3], txh_used_q [3], txh_lim_q [3];
    logic [11:0] rxd_in_q [3], rxd_out_q [3], txd_used_q [3], txd_lim_q [3];
    logic [7:0] rxh_in_d [3], rxh_out_d [3], txh_used_d [3], txh_lim_d [3];
    logic [11:0] rxd_in_d [3], rxd_out_d [3], txd_used_d [3], txd_lim_d [3];
    logic [7:0] h_init [3];
    logic [11:0] d_init [3];
    logic [7:0] h_av [3], h_lim [3], h_view [3];
    logic [11:0] d_av [3], d_lim [3], d_view [3];
    logic [2:0] view_q, view_d;
    logic [1:0] wp, rpl, sp, up;

    assign h_init = '{8'(ptb_pkg::ph_init(HIGH_PERF)), 8'(ptb_pkg::NPH_INIT),
        8'(ptb_pkg::cplh_init(HIGH_PERF))};
    assign d_init = '{12'(ptb_pkg::pd_init(PAYLOAD_BYTES, HIGH_PERF)),
        12'(ptb_pkg::NPD_INIT), 12'(ptb_pkg::pd_init(PAYLOAD_BYTES, HIGH_PERF))};
    assign wp = pool_of(rx_write_class);
    assign rpl = pool_of(rx_read_class);
    assign sp = pool_of(tx_send_class);
    assign up = pool_of(fc_update_class);

    always_comb begin
        view_d = credit_view_select;
        for (int p = 0; p < 3; p++) begin
            rxh_in_d[p] = rxh_in_q[p];
            rxd_in_d[p] = rxd_in_q[p];
            rxh_out_d[p] = rxh_out_q[p];
            rxd_out_d[p] = rxd_out_q[p];
            txh_used_d[p] = txh_used_q[p];
            txd_used_d[p] = txd_used_q[p];
            txh_lim_d[p] = txh_lim_q[p];
            txd_lim_d[p] = txd_lim_q[p];
            if (rx_write_valid && wp == 2'(p)) begin
                rxh_in_d[p] = rxh_in_q[p] + 8'h1;
                rxd_in_d[p] = rxd_in_q[p] + data_credits(rx_write_len);
            end
            if (rx_read_valid && rpl == 2'(p)) begin
                rxh_out_d[p] = rxh_out_q[p] + 8'h1;
                rxd_out_d[p] = rxd_out_q[p] + data_credits(rx_read_len);
            end
            if (tx_send_valid && sp == 2'(p)) begin
                txh_used_d[p] = txh_used_q[p] + 8'h1;
                txd_used_d[p] = txd_used_q[p] + data_credits(tx_send_len);
            end
            if (fc_update_valid && up == 2'(p)) begin
                txh_lim_d[p] = fc_update_hdr;
                txd_lim_d[p] = fc_update_data;
            end
            h_lim[p] = h_init[p] + rxh_out_q[p];
            d_lim[p] = d_init[p] + rxd_out_q[p];
            h_av[p] = (h_lim[p] - rxh_in_q[p]) > h_init[p] ? 8'h0 : h_lim[p] - rxh_in_q[p];
            d_av[p] = (d_lim[p] - rxd_in_q[p]) > d_init[p] ? 12'h0 : d_lim[p] - rxd_in_q[p];
            if (ENDPOINT && p == ptb_pkg::POOL_CPL) begin
                h_lim[p] = 8'h0;
                d_lim[p] = 12'h0;
            end
            unique case (view_q)
                ptb_pkg::VIEW_RX_AVAIL: begin
                    h_view[p] = h_av[p];
                    d_view[p] = d_av[p];
                end
                ptb_pkg::VIEW_RX_LIMIT: begin
                    h_view[p] = h_lim[p];
                    d_view[p] = d_lim[p];
                end
                ptb_pkg::VIEW_RX_USED: begin
                    h_view[p] = rxh_in_q[p];
                    d_view[p] = rxd_in_q[p];
                end
                ptb_pkg::VIEW_TX_AVAIL: begin
                    h_view[p] = txh_lim_q[p] == 8'h0 ? ptb_pkg::HDR_INFINITE
                        : txh_lim_q[p] - txh_used_q[p];
                    d_view[p] = txd_lim_q[p] == 12'h0 ? ptb_pkg::DATA_INFINITE
                        : txd_lim_q[p] - txd_used_q[p];
                end
                ptb_pkg::VIEW_TX_LIMIT: begin
                    h_view[p] = txh_lim_q[p];
                    d_view[p] = txd_lim_q[p];
                end
                ptb_pkg::VIEW_TX_USED: begin
                    h_view[p] = txh_used_q[p];
                    d_view[p] = txd_used_q[p];
                end
                default: begin
                    h_view[p] = 8'h0;
                    d_view[p] = 12'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            view_q <= 3'h0;
            rxh_in_q <= '{8'h0, 8'h0, 8'h0};
            rxh_out_q <= '{8'h0, 8'h0, 8'h0};
            txh_used_q <= '{8'h0, 8'h0, 8'h0};
            txh_lim_q <= '{8'h0, 8'h0, 8'h0};
            rxd_in_q <= '{12'h0, 12'h0, 12'h0};
            rxd_out_q <= '{12'h0, 12'h0, 12'h0};
            txd_used_q <= '{12'h0, 12'h0, 12'h0};
            txd_lim_q <= '{12'h0, 12'h0, 12'h0};
            {posted_header_credits, nonposted_header_credits} <= 16'h0;
            completion_header_credits <= 8'h0;
            {posted_data_credits, nonposted_data_credits} <= 24'h0;
            completion_data_credits <= 12'h0;
            device_control <= 16'h0;
        end else begin
            view_q <= view_d;
            rxh_in_q <= rxh_in_d;
            rxh_out_q <= rxh_out_d;
            txh_used_q <= txh_used_d;
            txh_lim_q <= txh_lim_d;
            rxd_in_q <= rxd_in_d;
            rxd_out_q <= rxd_out_d;
            txd_used_q <= txd_used_d;
            txd_lim_q <= txd_lim_d;
            posted_header_credits <= h_view[0];
            nonposted_header_credits <= h_view[1];
            completion_header_credits <= h_view[2];
            posted_data_credits <= d_view[0];
            nonposted_data_credits <= d_view[1];
            completion_data_credits <= d_view[2];
            device_control <= device_control_in;
        end
    end

    // ---------------- apb slave ----------------
    logic setup;
    logic [31:0] rdata_d;
    logic err_d;

    assign setup = psel && !penable;

    always_comb begin
        ctrl_d = ctrl_q;
        if (psel && penable && pready && pwrite && paddr == ptb_pkg::REG_CTRL) begin
            ctrl_d = {31'h0, pwdata[ptb_pkg::CTRL_TX_ENABLE]};
        end
        err_d = 1'b0;
        case (paddr)
            ptb_pkg::REG_CTRL: rdata_d = ctrl_q;
            ptb_pkg::REG_STATUS: rdata_d = {15'h0, np_credit_blocked, 2'h0, inflight_q,
                2'h0, free_q};
            ptb_pkg::REG_DEVCTL: rdata_d = {16'h0, device_control};
            ptb_pkg::REG_CONFIG: rdata_d = {14'h0, ENDPOINT, HIGH_PERF, 5'h0,
                11'(PAYLOAD_BYTES)};
            default: begin
                rdata_d = 32'h0;
                err_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= ptb_pkg::CTRL_RESET;
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            pready <= setup;
            prdata <= (setup && !pwrite) ? rdata_d : 32'h0;
            pslverr <= setup && err_d;
        end
    end

    // ---------------- checks ----------------
    logic pool_ok;
    assign pool_ok = free_q + inflight_q + cnt_q[0] + cnt_q[1] == POOL6;

    pool_sum_a: assert property (@(posedge clk) disable iff (rst) pool_ok)
        else $error("free, pending and in-flight buffers do not add up");
    free_out_a: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> transmit_buffers_free == free_q)
        else $error("free buffer output does not match pool count");
    ack_free_a: assert property (@(posedge clk) disable iff (rst)
        (release_buf && !take) |=> free_q == $past(free_q) + 6'h1)
        else $error("acknowledge did not free a buffer");
    load_take_a: assert property (@(posedge clk) disable iff (rst)
        (take && !release_buf) |=> free_q == $past(free_q) - 6'h1)
        else $error("accepted tlp did not consume a whole buffer");
    np_hold_a: assert property (@(posedge clk) disable iff (rst)
        pick_np |-> !np_credit_blocked)
        else $error("non-posted sent while blocked");
    order_keep_a: assert property (@(posedge clk) disable iff (rst)
        (pick_pc && vis_q[0] != 6'h0 && np_older) |-> np_credit_blocked)
        else $error("younger tlp passed an unblocked non-posted");
    view_delay_a: assert property (@(posedge clk) disable iff (rst)
        (credit_view_select == ptb_pkg::VIEW_RX_USED ##1
        credit_view_select == ptb_pkg::VIEW_RX_USED) |=>
        posted_header_credits == $past(rxh_in_q[0]))
        else $error("credit view not presented two cycles after select");
    drain_init_a: assert property (@(posedge clk) disable iff (rst)
        (rxh_in_q[1] == rxh_out_q[1]) |-> h_av[1] == h_init[1])
        else $error("drained non-posted header credits not back at initial value");
    devctl_a: assert property (@(posedge clk) disable iff (rst)
        ##1 device_control == $past(device_control_in))
        else $error("device control output not following its source");
    apb_ready_a: assert property (@(posedge clk) disable iff (rst)
        (psel && !penable) |=> pready)
        else $error("register access not answered in one cycle");
endmodule

// >>> tb/ptb_link_model.sv
/* ptb_link_model: link partner that acks each sent tlp after a set delay
   and withholds non-posted credit on command. Assumes the core's clk and rst. */
`timescale 1ns/1ps
module ptb_link_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic tx_send_valid,
    input wire logic block_np,
    input wire logic [3:0] ack_delay,
    output logic link_ack,
    output logic np_credit_blocked
);
    logic [5:0] pend_q;
    logic [3:0] wait_q;
    assign np_credit_blocked = block_np;
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_q <= 6'h00;
            wait_q <= 4'h0;
            link_ack <= 1'b0;
        end else if (pend_q != 6'h00 && wait_q >= ack_delay) begin
            link_ack <= 1'b1;
            wait_q <= 4'h0;
            pend_q <= pend_q - 6'h01 + {5'h00, tx_send_valid};
        end else begin
            link_ack <= 1'b0;
            wait_q <= (pend_q != 6'h00) ? wait_q + 4'h1 : 4'h0;
            pend_q <= pend_q + {5'h00, tx_send_valid};
        end
    end
endmodule

// >>> tb/tb_top.sv
/* tb_top: directed bench for ptb_core with a link partner model.
   Assumes a 256-byte, high performance endpoint build. */
`timescale 1ns/1ps
module tb_top;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, err, block_np;
    logic user_load_valid, user_load_ready, link_ack, tx_send_valid, np_credit_blocked;
    logic config_management_unit_valid, config_management_unit_ready;
    logic rx_write_valid, rx_read_valid, fc_update_valid;
    logic [1:0] user_load_class, config_management_unit_class, tx_send_class;
    logic [1:0] rx_write_class, rx_read_class, fc_update_class;
    logic [8:0] user_load_len, config_management_unit_len, tx_send_len;
    logic [8:0] rx_write_len, rx_read_len;
    logic [7:0] paddr, fc_update_hdr, posted_header_credits;
    logic [7:0] nonposted_header_credits, completion_header_credits;
    logic [11:0] fc_update_data, posted_data_credits, nonposted_data_credits;
    logic [11:0] completion_data_credits;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] credit_view_select;
    logic [5:0] transmit_buffers_free;
    logic [15:0] device_control_in, device_control;
    logic [3:0] ack_delay;
    int mismatches, cmp_count;
    wire [59:0] crd = {posted_header_credits, posted_data_credits, nonposted_header_credits,
        nonposted_data_credits, completion_header_credits, completion_data_credits};

    ptb_core #(.PAYLOAD_BYTES(256), .HIGH_PERF(1'b1), .ENDPOINT(1'b1), .X8_GEN2_128(1'b0))
        i_ptb_core (.*);
    ptb_link_model i_ptb_link_model (.*);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (s !== 1'b1 && n < 200);
        if (n >= 200) begin
            mismatches++;
            end_of_test();
        end
    endtask
    task automatic apb_read(input logic [7:0] a, input logic w = 1'b0,
            input logic [31:0] d = 32'h0);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 200);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            mismatches++;
            end_of_test();
        end
        @(posedge clk);
    endtask
    task automatic load(input logic [1:0] c, input logic [8:0] l);
        user_load_valid <= 1'b1;
        user_load_class <= c;
        user_load_len <= l;
        wait_hi(user_load_ready);
        @(posedge clk);
    endtask
    task automatic ord(input logic [1:0] a, input logic [1:0] b, input logic blk);
        block_np <= blk;
        load(a, 9'h001);
        load(b, 9'h002);
        user_load_valid <= 1'b0;
        wait_hi(tx_send_valid);
        chk(tx_send_class, blk ? b : a);
        chk(tx_send_len, blk ? 9'h002 : 9'h001);
        @(posedge clk);
        block_np <= 1'b0;
        wait_hi(tx_send_valid);
        chk(tx_send_class, blk ? a : b);
        chk(tx_send_len, blk ? 9'h001 : 9'h002);
        @(posedge clk);
    endtask
    task automatic rxp(input logic wr);
        rx_write_valid <= wr;
        rx_read_valid <= !wr;
        {rx_write_class, rx_read_class} <= {2{ptb_pkg::CLS_ATOMIC}};
        {rx_write_len, rx_read_len} <= {2{9'h030}};
        @(posedge clk);
        {rx_write_class, rx_read_class} <= {2{ptb_pkg::CLS_POSTED}};
        {rx_write_len, rx_read_len} <= {2{9'h005}};
        @(posedge clk);
        rx_write_valid <= 1'b0;
        rx_read_valid <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic vw(input logic [2:0] s, input logic [7:0] ph);
        credit_view_select <= s;
        @(posedge clk);
        @(negedge clk);
        chk(posted_header_credits, ph);
        @(negedge clk);
    endtask

    initial begin
        {rst, psel, penable, pwrite, user_load_valid, rx_write_valid} = 6'h20;
        {config_management_unit_valid, rx_read_valid, fc_update_valid, block_np} = 4'h0;
        {paddr, pwdata, user_load_class, user_load_len} = '0;
        {config_management_unit_class, config_management_unit_len, ack_delay} = '0;
        {rx_write_class, rx_write_len, rx_read_class, rx_read_len} = '0;
        {fc_update_class, fc_update_hdr, fc_update_data, credit_view_select} = '0;
        device_control_in = 16'h0000;
        mismatches = 0;
        cmp_count = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        device_control_in <= 16'h2830;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(transmit_buffers_free, 6'h1d);
        chk(crd, {8'h20, 12'h09a, 8'h0c, 12'h00c, 8'h24, 12'h09a});
        @(posedge clk);
        apb_read(ptb_pkg::REG_DEVCTL);
        chk(rd, 32'h0000_2830);
        chk(device_control, 16'h2830);
        apb_read(ptb_pkg::REG_CONFIG);
        chk(rd, 32'h0003_0100);
        apb_read(ptb_pkg::REG_CTRL, 1'b1, 32'h0);
        apb_read(ptb_pkg::REG_CTRL);
        chk(rd, 32'h0);
        apb_read(ptb_pkg::REG_CTRL, 1'b1, 32'h1);
        apb_read(ptb_pkg::REG_CTRL);
        chk(rd, 32'h1);
        apb_read(8'h40);
        chk(err, 1'b1);
        ack_delay <= 4'hf;
        config_management_unit_valid <= 1'b1;
        config_management_unit_class <= ptb_pkg::CLS_COMPLETION;
        config_management_unit_len <= 9'h001;
        wait_hi(config_management_unit_ready);
        @(posedge clk);
        config_management_unit_valid <= 1'b0;
        load(ptb_pkg::CLS_POSTED, 9'h004);
        user_load_valid <= 1'b0;
        @(negedge clk);
        chk(transmit_buffers_free, 6'h1b);
        for (int n = 0; n < 200 && transmit_buffers_free !== 6'h1d; n++) @(negedge clk);
        chk(transmit_buffers_free, 6'h1d);
        @(posedge clk);
        ack_delay <= 4'h2;
        ord(ptb_pkg::CLS_NONPOSTED, ptb_pkg::CLS_POSTED, 1'b1);
        ord(ptb_pkg::CLS_ATOMIC, ptb_pkg::CLS_COMPLETION, 1'b1);
        ord(ptb_pkg::CLS_NONPOSTED, ptb_pkg::CLS_POSTED, 1'b0);
        rxp(1'b1);
        chk(crd, {8'h1f, 12'h098, 8'h0b, 12'h000, 8'h24, 12'h09a});
        @(posedge clk);
        rxp(1'b0);
        chk(crd, {8'h20, 12'h09a, 8'h0c, 12'h00c, 8'h24, 12'h09a});
        @(posedge clk);
        vw(ptb_pkg::VIEW_TX_AVAIL, 8'h20);
        chk(crd, {8'h7f, 12'h7ff, 8'h7f, 12'h7ff, 8'h7f, 12'h7ff});
        @(posedge clk);
        vw(3'h3, 8'h7f);
        chk(crd, 60'h0);
        @(posedge clk);
        vw(ptb_pkg::VIEW_RX_LIMIT, 8'h00);
        chk(completion_header_credits, 8'h00);
        @(posedge clk);
        vw(ptb_pkg::VIEW_RX_USED, 8'h21);
        chk(crd, {8'h01, 12'h002, 8'h01, 12'h00c, 8'h00, 12'h000});
        @(posedge clk);
        fc_update_valid <= 1'b1;
        fc_update_hdr <= 8'h10;
        fc_update_data <= 12'h040;
        @(posedge clk);
        fc_update_valid <= 1'b0;
        vw(ptb_pkg::VIEW_TX_LIMIT, 8'h01);
        chk(crd, {8'h10, 12'h040, 8'h00, 12'h000, 8'h00, 12'h000});
        @(posedge clk);
        vw(ptb_pkg::VIEW_TX_USED, 8'h10);
        chk(crd, {8'h03, 12'h003, 8'h03, 12'h003, 8'h02, 12'h002});
        @(posedge clk);
        vw(ptb_pkg::VIEW_TX_AVAIL, 8'h03);
        chk(crd, {8'h0d, 12'h03d, 8'h7f, 12'h7ff, 8'h7f, 12'h7ff});
        end_of_test();
    end
endmodule
